// ### bpm_ctrl.sv
// Purpose: supervisory protection and mode control of a buck regulator
// Assumes: all inputs synchronous to clk_i; analog parts are inputs
// Notes:   rst_i stands for power-on-ready low
// Overview of operation
// - three-level pin picks one of three limits
// - sample current one eighth period before valley
// - short low-side pulse samples 40 ns in
// - sample above limit flags overcurrent
// - overcurrent latches flag, holds ramp at zero
// - after hiccup clear flag, start fresh ramp
// - hiccup retries repeat without limit
// - over temperature turns switches off, resets ramp
// - restart below trip minus 20 degrees
// - glide switching period toward external clock
// - sync lost glides back to free run
// - ramp is 0.15 rail, fixed below 6.2 V
// - zero-cross checked at low-side drive fall
// - 256 zero-cross cycles select low drive level
// - missing zero-cross clears count, selects high
// - every turn-on starts at high drive level
// - bias only, enable low holds low level
// - ramp starts at power ready, protection active
`timescale 1ns/100ps
module bpm_ctrl #(
  parameter int HICCUP_CYCLES = bpm_pkg::HICCUP_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    enable_i,
  input  wire logic [1:0]              oc_limit_select_i,
  input  wire logic [7:0]              isense_i,
  input  wire logic                    low_side_drive_i,
  input  wire logic                    zero_cross_i,
  input  wire logic [7:0]              temp_i,
  input  wire logic                    freq_set_sync_input_i,
  input  wire logic [15:0]             power_input_rail_mv_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         cycle_start_o,
  output logic                         switches_off_o,
  output logic                         ss_hold_o,
  output logic [15:0]                  ramp_mv_o,
  output logic                         gate_drive_regulator_low_o,
  output bpm_pkg::bpm_status_type      status_o
);
  import bpm_pkg::*;

  bpm_state_type  state_reg;
  logic [31:0]    hic_cnt_reg;
  logic           oc_flag_reg;
  logic [15:0]    int_period_reg;
  logic [23:0]    limits_reg;
  logic [15:0]    cur_period_reg;
  logic [15:0]    per_cnt_reg;
  logic [15:0]    ls_cnt_reg;
  logic [15:0]    ls_len_reg;
  logic           ls_prev_reg;
  logic           sync_prev_reg;
  logic [15:0]    ext_cnt_reg;
  logic [15:0]    ext_period_reg;
  logic           sync_lock_reg;
  logic [7:0]     zc_cnt_reg;
  logic           ldo_low_reg;
  logic           en_prev_reg;
  logic [15:0]    ramp_reg;
  logic           ack_reg;
  logic [31:0]    rdata_reg;
  logic [7:0]     limit_sel;
  logic [15:0]    eighth;
  logic           sample_now;
  logic           oc_event;
  logic           ls_fall;
  logic           sync_rise;
  logic           hot;
  logic [15:0]    target_period;
  logic           wb_req;
  logic [20:0]    ff_prod;

  // three-level pin decode; an illegal code falls back to the ground limit, limits_reg[7:0]
  always_comb begin
    unique case (oc_limit_select_i)
      OCSEL_OPEN: limit_sel = limits_reg[15:8];
      OCSEL_HIGH: limit_sel = limits_reg[23:16];
      default:    limit_sel = limits_reg[7:0];
    endcase
  end

  // sample point from last cycle's low-side length, one cycle late by design
  assign eighth = cur_period_reg >> SAMPLE_FRAC_SHIFT;
  always_comb begin
    if (ls_len_reg >= eighth) begin
      sample_now = low_side_drive_i &&
                   (ls_cnt_reg == ls_len_reg - eighth);
    end else begin
      sample_now = low_side_drive_i &&
                   (ls_cnt_reg == 16'(SHORT_DLY_CYC));
    end
  end
  // window shorter than a clock: a single sample
  assign oc_event = sample_now && (isense_i > limit_sel);
  assign hot      = temp_i >= TEMP_TRIP;
  assign ls_fall  = ls_prev_reg && !low_side_drive_i;
  assign sync_rise = freq_set_sync_input_i && !sync_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_prev_reg <= 1'b0;
      ls_cnt_reg  <= 16'h0000;
      ls_len_reg  <= 16'h0000;
    end else begin
      ls_prev_reg <= low_side_drive_i;
      if (low_side_drive_i) begin
        ls_cnt_reg <= ls_cnt_reg + 16'h0001;
      end else begin
        ls_cnt_reg <= 16'h0000;
      end
      if (ls_fall) begin
        ls_len_reg <= ls_cnt_reg;
      end
    end
  end

  // protection state; reset is power-on-ready low, so ramp starts on release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_RUN;
      hic_cnt_reg <= 32'h0000_0000;
      oc_flag_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (hot) begin
            state_reg   <= ST_THERMAL;
            hic_cnt_reg <= 32'h0000_0000;
          end else if (oc_event) begin
            state_reg   <= ST_HICCUP;
            oc_flag_reg <= 1'b1;
            hic_cnt_reg <= 32'h0000_0000;
          end
        end
        ST_HICCUP: begin
          if (hot) begin
            state_reg   <= ST_THERMAL;
            hic_cnt_reg <= 32'h0000_0000;
          end else if (hic_cnt_reg == 32'(HICCUP_CYCLES - 1)) begin
            state_reg   <= ST_RUN;
            oc_flag_reg <= 1'b0;
          end else begin
            hic_cnt_reg <= hic_cnt_reg + 32'h0000_0001;
          end
        end
        ST_THERMAL: begin
          hic_cnt_reg <= 32'h0000_0000;
          oc_flag_reg <= 1'b0;
          if (temp_i < TEMP_RESTART) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign switches_off_o = (state_reg == ST_THERMAL);
  assign ss_hold_o      = (state_reg != ST_RUN);

  // external clock watch: period between rising edges, loss by timeout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_prev_reg  <= 1'b0;
      ext_cnt_reg    <= 16'h0000;
      ext_period_reg <= PERIOD_RST;
      sync_lock_reg  <= 1'b0;
    end else begin
      sync_prev_reg <= freq_set_sync_input_i;
      if (sync_rise) begin
        ext_cnt_reg <= 16'h0001;
        if (ext_cnt_reg >= PERIOD_MIN && ext_cnt_reg < SYNC_LOSS) begin
          ext_period_reg <= ext_cnt_reg;
          sync_lock_reg  <= 1'b1;
        end
      end else if (ext_cnt_reg >= SYNC_LOSS) begin
        sync_lock_reg <= 1'b0;
      end else begin
        ext_cnt_reg <= ext_cnt_reg + 16'h0001;
      end
    end
  end

  assign target_period = sync_lock_reg ? ext_period_reg : int_period_reg;

  // one clock of period change per switching cycle keeps the loop calm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_cnt_reg    <= 16'h0000;
      cur_period_reg <= PERIOD_RST;
    end else if (per_cnt_reg >= cur_period_reg - 16'h0001) begin
      per_cnt_reg <= 16'h0000;
      if (cur_period_reg < target_period) begin
        cur_period_reg <= cur_period_reg + 16'h0001;
      end else if (cur_period_reg > target_period) begin
        cur_period_reg <= cur_period_reg - 16'h0001;
      end
    end else begin
      per_cnt_reg <= per_cnt_reg + 16'h0001;
    end
  end
  assign cycle_start_o = (per_cnt_reg == 16'h0000);

  // feed-forward ramp amplitude
  assign ff_prod = 21'(power_input_rail_mv_i) * 21'(FF_NUM);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_reg <= RAMP_FIX_MV;
    end else if (power_input_rail_mv_i < FF_MIN_MV) begin
      ramp_reg <= RAMP_FIX_MV;
    end else begin
      ramp_reg <= 16'(ff_prod / 21'(FF_DEN));
    end
  end
  assign ramp_mv_o = ramp_reg;

  // smart gate-drive level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_prev_reg <= 1'b0;
      zc_cnt_reg  <= 8'h00;
      ldo_low_reg <= 1'b1;
    end else begin
      en_prev_reg <= enable_i;
      if (!enable_i) begin
        ldo_low_reg <= 1'b1;
        zc_cnt_reg  <= 8'h00;
      end else if (!en_prev_reg) begin
        ldo_low_reg <= 1'b0;
        zc_cnt_reg  <= 8'h00;
      end else if (ls_fall) begin
        if (!zero_cross_i) begin
          zc_cnt_reg  <= 8'h00;
          ldo_low_reg <= 1'b0;
        end else if (zc_cnt_reg == ZC_LAST) begin
          ldo_low_reg <= 1'b1;
        end else begin
          zc_cnt_reg <= zc_cnt_reg + 8'h01;
        end
      end
    end
  end
  assign gate_drive_regulator_low_o = ldo_low_reg;

  assign status_o.ldo_low   = ldo_low_reg;
  assign status_o.ff_en     = ramp_reg != RAMP_FIX_MV ||
                              power_input_rail_mv_i >= FF_MIN_MV;
  assign status_o.sync_lock = sync_lock_reg;
  assign status_o.thermal   = switches_off_o;
  assign status_o.oc_flag   = oc_flag_reg;

  // ack one clock after strobe, writes land on the ack edge; unmapped read 0
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_PERIOD: rdata_reg <= {16'h0000, int_period_reg};
          REG_LIMITS: rdata_reg <= {8'h00, limits_reg};
          REG_STATUS: rdata_reg <= {27'h0000000, status_o};
          REG_CURPER: rdata_reg <= {16'h0000, cur_period_reg};
          default:    rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_period_reg <= PERIOD_RST;
      limits_reg     <= LIMITS_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_reg) begin
      if (wb_adr_i == REG_PERIOD) begin
        if (wb_sel_i[0]) int_period_reg[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) int_period_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == REG_LIMITS) begin
        if (wb_sel_i[0]) limits_reg[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) limits_reg[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) limits_reg[23:16] <= wb_dat_i[23:16];
      end
    end
  end

  // checks
  chk_limit_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    oc_limit_select_i == OCSEL_HIGH |-> limit_sel == limits_reg[23:16])
    else $error("limit select decode wrong");
  chk_oc_hiccup: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_RUN && oc_event && !hot
    |=> state_reg == ST_HICCUP && oc_flag_reg && ss_hold_o)
    else $error("overcurrent did not start hiccup");
  chk_hiccup_end: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_HICCUP && !hot &&
    hic_cnt_reg == 32'(HICCUP_CYCLES - 1)
    |=> state_reg == ST_RUN && !oc_flag_reg && !ss_hold_o)
    else $error("hiccup did not end on time");
  chk_hiccup_count: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_HICCUP && !hot && $past(state_reg) == ST_RUN
    |-> hic_cnt_reg == 32'h0000_0000)
    else $error("hiccup timer not cleared at entry");
  chk_thermal_off: assert property (@(posedge clk_i) disable iff (rst_i)
    hot |=> switches_off_o && ss_hold_o && hic_cnt_reg == 32'h0000_0000)
    else $error("over temperature left switches on");
  chk_thermal_hyst: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_THERMAL && temp_i >= TEMP_RESTART
    |=> state_reg == ST_THERMAL)
    else $error("thermal restart ignored hysteresis");
  chk_period_glide: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (cur_period_reg == $past(cur_period_reg) ||
    cur_period_reg == $past(cur_period_reg) + 16'h0001 ||
    cur_period_reg == $past(cur_period_reg) - 16'h0001))
    else $error("switching period jumped");
  chk_ff_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    power_input_rail_mv_i < FF_MIN_MV |=> ramp_mv_o == RAMP_FIX_MV)
    else $error("ramp not fixed at low rail");
  chk_zc_low: assert property (@(posedge clk_i) disable iff (rst_i)
    enable_i && en_prev_reg && ls_fall && zero_cross_i &&
    zc_cnt_reg == ZC_LAST |=> gate_drive_regulator_low_o)
    else $error("low drive not selected after full count");
  chk_zc_high: assert property (@(posedge clk_i) disable iff (rst_i)
    enable_i && en_prev_reg && ls_fall && !zero_cross_i
    |=> !gate_drive_regulator_low_o && zc_cnt_reg == 8'h00)
    else $error("missing zero cross kept low drive");
  chk_turn_on_high: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(enable_i) |=> ##1 !gate_drive_regulator_low_o)
    else $error("turn-on did not start at high drive");
  chk_bias_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i |=> gate_drive_regulator_low_o)
    else $error("bias only did not hold low drive");

  cov_hiccup_retry: cover property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_HICCUP ##1 state_reg == ST_RUN);
  cov_thermal_exit: cover property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_THERMAL ##1 state_reg == ST_RUN);
  cov_sync_lock: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(sync_lock_reg));
  cov_ldo_low: cover property (@(posedge clk_i) disable iff (rst_i)
    enable_i && $rose(gate_drive_regulator_low_o));
endmodule

// ### bpm_pkg.sv
// Purpose: shared constants and types for buck protection mode control
// Assumes: 25 MHz system clock, one switching cycle is many clocks
// Notes:   register map sits on a classic wishbone slave, word aligned
package bpm_pkg;
  localparam int CLK_KHZ           = 25000;
  localparam int CLK_NS            = 40;
  // times in their own units and derived clock counts
  localparam int SAMPLE_WIN_NS     = 30;
  localparam int SAMPLE_WIN_CYC    = (SAMPLE_WIN_NS / CLK_NS) < 1 ? 1 :
                                     (SAMPLE_WIN_NS / CLK_NS);
  localparam int SHORT_DLY_NS      = 40;
  localparam int SHORT_DLY_CYC     = (SHORT_DLY_NS / CLK_NS) < 1 ? 1 :
                                     (SHORT_DLY_NS / CLK_NS);
  localparam int HICCUP_US         = 20480;
  localparam int HICCUP_CYC        = HICCUP_US * (CLK_KHZ / 1000);
  localparam int SAMPLE_FRAC_SHIFT = 3;
  // thermal, degrees celsius
  localparam logic [7:0]  TEMP_TRIP    = 8'h91;
  localparam logic [7:0]  TEMP_HYST    = 8'h14;
  localparam logic [7:0]  TEMP_RESTART = TEMP_TRIP - TEMP_HYST;
  // feed-forward, millivolts
  localparam logic [15:0] FF_MIN_MV    = 16'h1838;
  localparam logic [15:0] RAMP_FIX_MV  = 16'h0384;
  localparam logic [4:0]  FF_NUM       = 5'h03;
  localparam logic [4:0]  FF_DEN       = 5'h14;
  // smart gate drive
  localparam logic [7:0]  ZC_LAST      = 8'hff;
  // sync loss timeout in clocks
  localparam logic [15:0] SYNC_LOSS    = 16'h0400;
  // limit select pin codes
  localparam logic [1:0]  OCSEL_GND    = 2'h0;
  localparam logic [1:0]  OCSEL_OPEN   = 2'h1;
  localparam logic [1:0]  OCSEL_HIGH   = 2'h2;
  // register map, byte addresses
  localparam logic [7:0]  REG_PERIOD   = 8'h00;
  localparam logic [7:0]  REG_LIMITS   = 8'h04;
  localparam logic [7:0]  REG_STATUS   = 8'h08;
  localparam logic [7:0]  REG_CURPER   = 8'h0c;
  localparam logic [15:0] PERIOD_RST   = 16'h002a;
  localparam logic [23:0] LIMITS_RST   = 24'h605040;
  localparam logic [15:0] PERIOD_MIN   = 16'h0010;

  typedef enum {ST_RUN, ST_HICCUP, ST_THERMAL} bpm_state_type;

  typedef struct packed {
    logic ldo_low;
    logic ff_en;
    logic sync_lock;
    logic thermal;
    logic oc_flag;
  } bpm_status_type;
endpackage

// ### bpm_stage_model.sv
// Purpose: power stage, die sensor and sync source seen by bpm_ctrl
// Assumes: one low-side pulse of fixed length per switching cycle
// Notes:   sensed current shows the inverse level while low side is off
`timescale 1ns/100ps
module bpm_stage_model #(
  parameter int LS_LEN = 20
) (
  input  wire logic        clk_i,
  input  wire logic        cycle_start_i,
  input  wire logic        switches_off_i,
  input  wire logic [7:0]  cur_i,
  input  wire logic        zc_on_i,
  input  wire logic [7:0]  temp_set_i,
  input  wire logic        sync_on_i,
  input  wire logic [15:0] sync_per_i,
  output logic             low_side_drive_o,
  output logic [7:0]       isense_o,
  output logic             zero_cross_o,
  output logic [7:0]       temp_o,
  output logic             sync_o
);
  int ls_cnt   = 0;
  int sync_cnt = 0;
  always_ff @(posedge clk_i) begin
    if (switches_off_i) begin
      ls_cnt <= 0;
    end else if (cycle_start_i) begin
      ls_cnt <= LS_LEN;
    end else if (ls_cnt > 0) begin
      ls_cnt <= ls_cnt - 1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!sync_on_i || sync_cnt >= int'(sync_per_i) - 1) begin
      sync_cnt <= 0;
    end else begin
      sync_cnt <= sync_cnt + 1;
    end
  end
  assign low_side_drive_o = (ls_cnt > 0);
  // no stale value off the sample window, so a loose sample point shows
  assign isense_o         = low_side_drive_o ? cur_i : ~cur_i;
  assign zero_cross_o     = zc_on_i;
  assign temp_o           = temp_set_i;
  // sync line idles low while the external clock is absent
  assign sync_o           = sync_on_i && (sync_cnt == 0);
endmodule

// ### bpm_ctrl_test.sv
// Purpose: self-checking bench for bpm_ctrl
// Assumes: hiccup shortened to HIC clocks, default free-run period
// Notes:   outputs are sampled on the falling clock edge, bus ack and read data on the rising edge
`timescale 1ns/100ps
module bpm_ctrl_test;
  import bpm_pkg::*;
  localparam int HIC = 50;
  logic           clk_i, rst_i, enable, zc_on, sync_on, ls, zc, sy;
  logic           wb_we, wb_cyc, wb_stb, wb_ack_o, cyc_st, sw_off, hold;
  logic           gate_drive_regulator;
  logic [1:0]     ocsel;
  logic [3:0]     wb_sel;
  logic [7:0]     cur, temp_set, isense, temp, wb_adr;
  logic [15:0]    rail, sync_per, ramp;
  logic [31:0]    wb_dat, wb_dat_o, d;
  bpm_status_type st;
  int             err_total, checked, n;

  bpm_ctrl #(.HICCUP_CYCLES(HIC)) bpm_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
    .enable_i(enable), .oc_limit_select_i(ocsel), .isense_i(isense),
    .low_side_drive_i(ls), .zero_cross_i(zc), .temp_i(temp),
    .freq_set_sync_input_i(sy), .power_input_rail_mv_i(rail),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cycle_start_o(cyc_st), .switches_off_o(sw_off),
    .ss_hold_o(hold), .ramp_mv_o(ramp), .gate_drive_regulator_low_o(gate_drive_regulator),
    .status_o(st));
  bpm_stage_model bpm_stage_model_i (.clk_i(clk_i), .cycle_start_i(cyc_st),
    .switches_off_i(sw_off), .cur_i(cur), .zc_on_i(zc_on),
    .temp_set_i(temp_set), .sync_on_i(sync_on), .sync_per_i(sync_per),
    .low_side_drive_o(ls), .isense_o(isense), .zero_cross_o(zc),
    .temp_o(temp), .sync_o(sy));

  task results;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  // master holds the request until ack is sampled high, then releases
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] dw, input logic [3:0] sel);
    int w;
    w = 0;
    @(posedge clk_i);
    wb_adr <= a;
    wb_we  <= we;
    wb_dat <= dw;
    wb_sel <= sel;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && w < 20) begin
      w++;
      @(posedge clk_i);
    end
    d = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (w >= 20) chk(32'h0, 32'h1);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(d, exp);
  endtask
  task automatic wait_hold(input logic v, input int max);
    n = 0;
    while (hold !== v && n < max) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic wait_falls(input int k);
    int f, t;
    logic p;
    f = 0;
    t = 0;
    p = ls;
    while (f < k && t < k * 60) begin
      @(negedge clk_i);
      t++;
      if (p === 1'b1 && ls === 1'b0) f++;
      p = ls;
    end
    cyc(2);
  endtask
  task wait_start;
    n = 1;
    @(negedge clk_i);
    while (cyc_st !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task t_reset;
    chk_bit(hold, 1'b0);
    chk_bit(sw_off, 1'b0);
    cyc(4);
    chk_bit(gate_drive_regulator, 1'b0);
  endtask
  task t_regs;
    rdchk(REG_PERIOD, {16'h0, PERIOD_RST});
    rdchk(REG_LIMITS, {8'h0, LIMITS_RST});
    wb(1'b1, 8'h10, 32'hffffffff, 4'hf);
    rdchk(8'h10, 32'h0);
    wb(1'b1, REG_STATUS, 32'hffffffff, 4'hf);
    rdchk(REG_STATUS, 32'h0);
    wb(1'b1, REG_LIMITS, 32'h00000030, 4'h1);
    rdchk(REG_LIMITS, 32'h00605030);
    wb(1'b1, REG_LIMITS, {8'h0, LIMITS_RST}, 4'hf);
    rdchk(REG_CURPER, {16'h0, PERIOD_RST});
  endtask
  task automatic t_oc;
    logic [7:0] lim;
    for (int c = 0; c < 4; c++) begin
      lim = LIMITS_RST[8 * (c == 3 ? 0 : c) +: 8];
      @(posedge clk_i);
      ocsel <= 2'(c);
      cur   <= lim;
      cyc(150);
      chk_bit(hold, 1'b0);
      @(posedge clk_i);
      cur <= lim + 8'h01;
      wait_hold(1'b1, 150);
      chk_bit(st.oc_flag, 1'b1);
      @(posedge clk_i);
      cur <= 8'h10;
      // wait opens one clock into hiccup and closes a half clock late
      wait_hold(1'b0, 200);
      chk(n, HIC);
      chk_bit(st.oc_flag, 1'b0);
    end
    @(posedge clk_i);
    cur <= 8'h41;
    wait_hold(1'b1, 150);
    wait_hold(1'b0, 200);
    wait_hold(1'b1, 150);
    chk_bit(n < 150, 1'b1);
  endtask
  task t_therm;
    @(posedge clk_i);
    temp_set <= 8'd144;
    cyc(20);
    chk_bit(sw_off, 1'b0);
    @(posedge clk_i);
    temp_set <= 8'd145;
    cyc(3);
    chk_bit(sw_off, 1'b1);
    chk_bit(st.thermal, 1'b1);
    @(posedge clk_i);
    cur      <= 8'h10;
    temp_set <= 8'd125;
    cyc(HIC + 10);
    chk_bit(sw_off, 1'b1);
    chk_bit(hold, 1'b1);
    @(posedge clk_i);
    temp_set <= 8'd124;
    cyc(3);
    chk_bit(sw_off, 1'b0);
    chk_bit(hold, 1'b0);
  endtask
  task automatic t_ff;
    logic [15:0] rv [4] = '{16'd12000, 16'd6200, 16'd6199, 16'd5000};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      rail <= rv[i];
      cyc(3);
      chk(32'(ramp), rv[i] >= 16'd6200 ? 32'(rv[i]) * 3 / 20 : 32'd900);
      chk_bit(st.ff_en, rv[i] >= 16'd6200);
    end
  endtask
  task t_ldo;
    @(posedge clk_i);
    enable <= 1'b0;
    cyc(2);
    chk_bit(gate_drive_regulator, 1'b1);
    @(posedge clk_i);
    enable <= 1'b1;
    cyc(3);
    chk_bit(gate_drive_regulator, 1'b0);
    @(posedge clk_i);
    zc_on <= 1'b1;
    wait_falls(250);
    chk_bit(gate_drive_regulator, 1'b0);
    wait_falls(5);
    chk_bit(gate_drive_regulator, 1'b0);
    wait_falls(1);
    chk_bit(gate_drive_regulator, 1'b1);
    chk_bit(st.ldo_low, 1'b1);
    @(posedge clk_i);
    zc_on <= 1'b0;
    wait_falls(2);
    chk_bit(gate_drive_regulator, 1'b0);
  endtask
  task automatic t_sync;
    logic [15:0] pv [2] = '{16'd60, 16'd30};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      sync_per <= pv[i];
      sync_on  <= 1'b1;
      cyc(300);
      wb(1'b0, REG_CURPER, 32'h0, 4'hf);
      chk_bit(d != 32'd42 && d != 32'(pv[i]), 1'b1);
      cyc(5000);
      rdchk(REG_CURPER, 32'(pv[i]));
      chk_bit(st.sync_lock, 1'b1);
      wait_start;
      wait_start;
      chk(n, 32'(pv[i]));
      @(posedge clk_i);
      sync_on <= 1'b0;
      for (n = 0; n < 1200 && st.sync_lock !== 1'b0; n++) @(negedge clk_i);
      chk_bit(st.sync_lock, 1'b0);
      wb(1'b0, REG_CURPER, 32'h0, 4'hf);
      chk_bit(d != 32'd42, 1'b1);
      cyc(3000);
      rdchk(REG_CURPER, 32'd42);
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    err_total++;
    results;
  end
  initial begin
    err_total = 0;
    checked   = 0;
    rst_i     = 1'b1;
    enable    = 1'b1;
    ocsel     = OCSEL_GND;
    cur       = 8'h10;
    zc_on     = 1'b0;
    temp_set  = 8'd40;
    sync_on   = 1'b0;
    sync_per  = 16'd60;
    rail      = 16'd5000;
    {wb_we, wb_cyc, wb_stb, wb_adr, wb_dat, wb_sel} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    t_reset;
    t_regs;
    t_oc;
    t_therm;
    t_ff;
    t_ldo;
    t_sync;
    results;
  end
endmodule
